// >>> verilog/csr_clock_ctrl.v
`include "csr_consts.vh"

module csr_clock_ctrl #(
    parameter STARTUP_CYCLES = `CSR_STARTUP_CYCLES
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst_n,
    // Register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Configuration straps
    input  wire [3:0] primary_osc_config,
    input  wire [1:0] secondary_osc_run_mode,
    // Core events and clock sources as enables
    input  wire       sleep_instr,
    input  wire       wake_event,
    input  wire       primary_tick,
    input  wire       secondary_tick,
    input  wire       low_freq_tick,
    input  wire       high_freq_tick,
    // Outputs
    output reg        secondary_osc_enable,
    output reg        secondary_digital_in,
    output reg        device_clk_tick,
    output reg        quadrature_phase_first,
    output reg        quadrature_phase_fourth,
    output reg        instr_rate_clock_out,
    output reg        refclk_out_pin,
    output reg        wdt_clk_tick,
    output reg        sleep_active,
    output reg        idle_active
);

    // ****************************************
    // Registers
    // ****************************************
    reg        idle_on_sleep_select;
    reg [1:0]  system_clock_select;
    reg        secondary_osc_warmup;
    reg        timer_secondary_osc_select;
    reg        refclk_out_enable;
    reg        refclk_run_in_sleep;
    reg        refclk_source_select;
    reg [3:0]  refclk_divisor;
    reg        primary_clock_active;
    reg        secondary_clock_active;
    reg [1:0]  active_src;
    reg [2:0]  switch_cnt;
    reg [15:0] startup_cnt;
    reg        startup_done;
    reg [1:0]  quad_phase;
    reg [14:0] ref_cnt;
    reg        ref_base_q;

    wire crystal_mode = (primary_osc_config == `CSR_PRI_LP) ||
                        (primary_osc_config == `CSR_PRI_XT) ||
                        (primary_osc_config == `CSR_PRI_HS) ||
                        (primary_osc_config == `CSR_PRI_HS_ALT);
    wire internal_oscillator_primary = (primary_osc_config == `CSR_PRI_INTERNAL_OSCILLATOR) ||
                          (primary_osc_config == `CSR_PRI_INTERNAL_OSCILLATOR_ALT);
    wire stopped = sleep_active;

    // ****************************************
    // Register writes
    // ****************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idle_on_sleep_select       <= 1'b0;
            system_clock_select        <= 2'h0;
            secondary_osc_warmup       <= 1'b0;
            timer_secondary_osc_select <= 1'b0;
            refclk_out_enable          <= 1'b0;
            refclk_run_in_sleep        <= 1'b0;
            refclk_source_select       <= 1'b0;
            refclk_divisor             <= 4'h0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `CSR_ADDR_OSC_CTRL:
                begin
                    idle_on_sleep_select <= reg_wdata[`CSR_OSC_IDLE_BIT];
                    system_clock_select  <= reg_wdata[1:0];
                end
                `CSR_ADDR_OSC_CTRL2:
                    secondary_osc_warmup <=
                        reg_wdata[`CSR_OSC_OUTPUT_PIN_WARMUP_BIT];
                `CSR_ADDR_TIMER_CTRL:
                    timer_secondary_osc_select <=
                        reg_wdata[`CSR_TMR_SEC_SEL_BIT];
                `CSR_ADDR_REFCLK_CTRL:
                begin
                    refclk_out_enable    <= reg_wdata[`CSR_REF_EN_BIT];
                    refclk_run_in_sleep  <= reg_wdata[`CSR_REF_SLP_BIT];
                    refclk_source_select <= reg_wdata[`CSR_REF_SRC_BIT];
                    refclk_divisor       <= reg_wdata[3:0];
                end
                // Unmapped offsets are ignored
                default: ;
            endcase
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= `CSR_RST_BYTE;
        else if (reg_rd)
        begin
            reg_rdata <= `CSR_RST_BYTE;
            case (reg_addr)
                `CSR_ADDR_OSC_CTRL:
                begin
                    reg_rdata[`CSR_OSC_IDLE_BIT]    <= idle_on_sleep_select;
                    reg_rdata[`CSR_OSC_PRI_ACT_BIT] <= primary_clock_active;
                    reg_rdata[1:0]                  <= system_clock_select;
                end
                `CSR_ADDR_OSC_CTRL2:
                begin
                    reg_rdata[`CSR_OSC_OUTPUT_PIN_SEC_ACT_BIT] <=
                        secondary_clock_active;
                    reg_rdata[`CSR_OSC_OUTPUT_PIN_WARMUP_BIT]  <= secondary_osc_warmup;
                end
                `CSR_ADDR_TIMER_CTRL:
                    reg_rdata[`CSR_TMR_SEC_SEL_BIT] <=
                        timer_secondary_osc_select;
                `CSR_ADDR_REFCLK_CTRL:
                    // Bit 6 left at zero
                    reg_rdata <= {refclk_out_enable, 1'b0,
                                  refclk_run_in_sleep, refclk_source_select,
                                  refclk_divisor};
                default: ;
            endcase
        end
        // Data stand one cycle only, then read back as zero
        else
            reg_rdata <= `CSR_RST_BYTE;
    end

    // ****************************************
    // Secondary oscillator control
    // ****************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            secondary_osc_enable <= 1'b0;
            secondary_digital_in <= 1'b0;
        end
        else
        begin
            // Not gated by sleep so it survives power-managed modes
            secondary_osc_enable <= timer_secondary_osc_select ||
                (system_clock_select == `CSR_SCS_SECONDARY) ||
                secondary_osc_warmup;
            secondary_digital_in <=
                (secondary_osc_run_mode == `CSR_SEC_MODE_DIGITAL);
        end
    end

    // ****************************************
    // Primary start-up and source switch
    // ****************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            startup_cnt  <= 16'h0000;
            startup_done <= 1'b0;
        end
        // Outside crystal mode start-up is marked done; no restart on return
        else if (!crystal_mode)
            startup_done <= 1'b1;
        else if (!startup_done && primary_tick)
        begin
            if (startup_cnt == STARTUP_CYCLES - 1)
                startup_done <= 1'b1;
            else
                startup_cnt <= startup_cnt + 16'h0001;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_src <= 2'h3;
            switch_cnt <= 3'h0;
        end
        else if (active_src != system_clock_select)
        begin
            // Brief transition before the new source takes over
            // Old source keeps driving the clock during the count
            if (switch_cnt == `CSR_SWITCH_CYCLES - 1)
            begin
                active_src <= system_clock_select;
                switch_cnt <= 3'h0;
            end
            else
                switch_cnt <= switch_cnt + 3'h1;
        end
        else
            switch_cnt <= 3'h0;
    end

    // ****************************************
    // Status bits
    // ****************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            primary_clock_active   <= 1'b0;
            secondary_clock_active <= 1'b0;
        end
        else
        begin
            primary_clock_active <= (active_src == `CSR_SCS_PRIMARY) &&
                startup_done && !internal_oscillator_primary;
            secondary_clock_active <=
                (active_src == `CSR_SCS_SECONDARY);
        end
    end

    // ****************************************
    // Source tick pick
    // ****************************************
    reg src_tick;
    always @*
    begin
        case (active_src)
            `CSR_SCS_PRIMARY:
                src_tick = internal_oscillator_primary ? high_freq_tick
                         : (startup_done & primary_tick);
            `CSR_SCS_SECONDARY:
                src_tick = secondary_tick;
            default:
                src_tick = high_freq_tick;
        endcase
    end

    // ****************************************
    // Sleep and idle
    // ****************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleep_active <= 1'b0;
            idle_active  <= 1'b0;
        end
        // Wake wins over a sleep strobe in the same cycle
        else if (wake_event)
        begin
            sleep_active <= 1'b0;
            idle_active  <= 1'b0;
        end
        else if (sleep_instr)
        begin
            sleep_active <= !idle_on_sleep_select;
            idle_active  <= idle_on_sleep_select;
        end
    end

    // ****************************************
    // Quadrature phases
    // ****************************************
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quad_phase              <= 2'h0;
            device_clk_tick         <= 1'b0;
            quadrature_phase_first  <= 1'b0;
            quadrature_phase_fourth <= 1'b0;
            instr_rate_clock_out    <= 1'b0;
            wdt_clk_tick            <= 1'b0;
        end
        else
        begin
            wdt_clk_tick    <= low_freq_tick;
            device_clk_tick <= src_tick && !stopped;
            quadrature_phase_first  <= 1'b0;
            quadrature_phase_fourth <= 1'b0;
            // Crystal owns the output pin, so the rate clock stays low
            if (crystal_mode)
                instr_rate_clock_out <= 1'b0;
            // Idle keeps device ticks and stops the phases and the rate clock
            if (src_tick && !stopped && !idle_active)
            begin
                quad_phase <= quad_phase + 2'h1;
                quadrature_phase_first  <= (quad_phase == 2'h0);
                quadrature_phase_fourth <= (quad_phase == 2'h3);
                // High for first half of each instruction cycle
                instr_rate_clock_out <= !quad_phase[1] &&
                    !(crystal_mode);
            end
        end
    end

    // ****************************************
    // Reference clock output
    // ****************************************
    wire ref_base = refclk_source_select ?
                    (primary_tick && !internal_oscillator_primary)
                  : device_clk_tick;
    wire ref_run  = refclk_out_enable &&
                    (!sleep_active || refclk_run_in_sleep);
    wire [14:0] ref_mask = (15'h0001 << refclk_divisor) - 15'h0001;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_cnt        <= 15'h0000;
            ref_base_q     <= 1'b0;
            refclk_out_pin <= 1'b0;
        end
        else if (!ref_run)
        begin
            ref_cnt        <= 15'h0000;
            ref_base_q     <= 1'b0;
            refclk_out_pin <= 1'b0;
        end
        else if (refclk_divisor == 4'h0)
        begin
            // Divider follows the pin so a later divisor starts clean
            ref_cnt        <= 15'h0000;
            ref_base_q     <= ref_base;
            refclk_out_pin <= ref_base;
        end
        else if (ref_base)
        begin
            // Toggle on every 2^(n-1) base ticks gives divide by 2^n
            if ((ref_cnt & (ref_mask >> 1)) == (ref_mask >> 1))
            begin
                ref_base_q     <= !ref_base_q;
                refclk_out_pin <= !ref_base_q;
            end
            ref_cnt <= ref_cnt + 15'h0001;
        end
    end

endmodule // csr_clock_ctrl

// >>> pkg/csr_consts.vh
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define CSR_ADDR_OSC_CTRL    4'h0
`define CSR_ADDR_OSC_CTRL2   4'h1
`define CSR_ADDR_REFCLK_CTRL 4'h2
`define CSR_ADDR_TIMER_CTRL  4'h3

// ****************************************
// Field positions
// ****************************************
`define CSR_OSC_IDLE_BIT     7
`define CSR_OSC_PRI_ACT_BIT  3
`define CSR_OSC_OUTPUT_PIN_SEC_ACT_BIT 6
`define CSR_OSC_OUTPUT_PIN_WARMUP_BIT  3
`define CSR_TMR_SEC_SEL_BIT  3
`define CSR_REF_EN_BIT       7
`define CSR_REF_SLP_BIT      5
`define CSR_REF_SRC_BIT      4

// ****************************************
// Encodings
// ****************************************
`define CSR_SCS_PRIMARY      2'h0
`define CSR_SCS_SECONDARY    2'h1
`define CSR_SEC_MODE_DIGITAL 2'h2
`define CSR_PRI_LP           4'h0
`define CSR_PRI_XT           4'h1
`define CSR_PRI_HS           4'h2
`define CSR_PRI_HS_ALT       4'h3
`define CSR_PRI_INTERNAL_OSCILLATOR       4'h8
`define CSR_PRI_INTERNAL_OSCILLATOR_ALT   4'h9

// ****************************************
// Reset values and timing
// ****************************************
`define CSR_RST_BYTE         8'h00
`define CSR_STARTUP_CYCLES   1024
`define CSR_SWITCH_CYCLES    4

`endif

// >>> testbench/csr_osc_model.sv
// ****
// Crystal and oscillator sources as tick pulses
// ****
module csr_osc_model (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // Request from the block
    input  wire        secondary_osc_enable,
    // Source ticks
    output logic       primary_tick,
    output logic       secondary_tick,
    output logic       low_freq_tick,
    output logic       high_freq_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt            <= 4'h0;
            primary_tick   <= 1'b0;
            secondary_tick <= 1'b0;
            low_freq_tick  <= 1'b0;
            high_freq_tick <= 1'b0;
        end
        else
        begin
            cnt            <= cnt + 4'h1;
            primary_tick   <= cnt[0];
            high_freq_tick <= 1'b1;
            low_freq_tick  <= (cnt == 4'hF);
            // Crystal only swings while requested, sleep or not
            secondary_tick <= secondary_osc_enable && (cnt[2:0] == 3'h7);
        end
    end
endmodule // csr_osc_model

// >>> testbench/csr_clock_ctrl_assertions.sv
// ****
// Port checker
// ****
module csr_ctrl_checker #(
    parameter STARTUP_CYCLES = 1024
) (
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Straps and sources
    input wire [3:0] primary_osc_config,
    input wire [1:0] secondary_osc_run_mode,
    input wire       low_freq_tick,
    // Outputs watched
    input wire       secondary_osc_enable,
    input wire       secondary_digital_in,
    input wire       device_clk_tick,
    input wire       quadrature_phase_first,
    input wire       instr_rate_clock_out,
    input wire       refclk_out_pin,
    input wire       wdt_clk_tick,
    input wire       sleep_active,
    input wire       idle_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_wdt_tick_follow:
        assert property ($past(rst_n) |-> wdt_clk_tick == $past(low_freq_tick))
            else $error("watchdog tick not one cycle behind");
    a_ref_bit6_zero:
        assert property ($past(reg_rd) && $past(reg_addr) == 4'h2
            |-> !reg_rdata[6]) else $error("reference bit 6 read as one");
    a_warmup_enable:
        assert property (reg_wr && reg_addr == 4'h1 && reg_wdata[3]
            |-> ##2 secondary_osc_enable) else $error("warm-up did not enable");
    a_select_enable:
        assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] == 2'h1
            |-> ##2 secondary_osc_enable) else $error("select did not enable");
    a_ref_off_quiet:
        assert property (reg_wr && reg_addr == 4'h2 && !reg_wdata[7] ##1 !reg_wr
            |-> ##2 (!refclk_out_pin)[*4])
            else $error("reference pin active");
    a_sleep_no_tick:
        assert property (sleep_active && $past(sleep_active)
            |-> !device_clk_tick) else $error("device tick during sleep");
    a_phase_spacing:
        assert property (quadrature_phase_first
            |=> (!quadrature_phase_first)[*3])
            else $error("phases too close");
    a_modes_exclusive:
        assert property (!(sleep_active && idle_active))
            else $error("sleep and idle together");
    a_crystal_no_instr_rate_clock_out:
        assert property (primary_osc_config < 4'h4 |-> !instr_rate_clock_out)
            else $error("rate clock out in crystal mode");
    a_digital_mode:
        assert property ($past(rst_n) && $stable(secondary_osc_run_mode)
            |-> secondary_digital_in == (secondary_osc_run_mode == 2'h2))
            else $error("digital input mode wrong");

    cover property (sleep_active);
    cover property (idle_active);
    cover property ($rose(refclk_out_pin));
endmodule // csr_ctrl_checker

bind csr_clock_ctrl csr_ctrl_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_i (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .primary_osc_config, .secondary_osc_run_mode, .low_freq_tick,
    .secondary_osc_enable, .secondary_digital_in, .device_clk_tick,
    .quadrature_phase_first, .instr_rate_clock_out, .refclk_out_pin,
    .wdt_clk_tick, .sleep_active, .idle_active
);

// >>> testbench/test_clock_source_select_and_refclk.sv
// ****
// Self-checking bench
// ****
module test_clock_source_select_and_refclk;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys, rst_n, reg_wr, reg_rd, sleep_instr, wake_event;
    logic [3:0] reg_addr, primary_osc_config;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] secondary_osc_run_mode;
    logic       primary_tick, secondary_tick, low_freq_tick, high_freq_tick;
    logic       secondary_osc_enable, secondary_digital_in, device_clk_tick;
    logic       quadrature_phase_first, quadrature_phase_fourth;
    logic       instr_rate_clock_out, refclk_out_pin, wdt_clk_tick;
    logic       sleep_active, idle_active;
    integer     mismatches, n_tests, cyc, t_dev, t_ref, t_q, t_q4, t_instr_rate_clock_out;

    csr_clock_ctrl #(.STARTUP_CYCLES(4)) csr_clock_ctrl_i (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .primary_osc_config(primary_osc_config),
        .secondary_osc_run_mode(secondary_osc_run_mode),
        .sleep_instr(sleep_instr), .wake_event(wake_event),
        .primary_tick(primary_tick), .secondary_tick(secondary_tick),
        .low_freq_tick(low_freq_tick), .high_freq_tick(high_freq_tick),
        .secondary_osc_enable(secondary_osc_enable),
        .secondary_digital_in(secondary_digital_in),
        .device_clk_tick(device_clk_tick),
        .quadrature_phase_first(quadrature_phase_first),
        .quadrature_phase_fourth(quadrature_phase_fourth),
        .instr_rate_clock_out(instr_rate_clock_out),
        .refclk_out_pin(refclk_out_pin), .wdt_clk_tick(wdt_clk_tick),
        .sleep_active(sleep_active), .idle_active(idle_active)
    );
    csr_osc_model csr_osc_model_i (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .secondary_osc_enable(secondary_osc_enable),
        .primary_tick(primary_tick), .secondary_tick(secondary_tick),
        .low_freq_tick(low_freq_tick), .high_freq_tick(high_freq_tick)
    );

    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    task close_out;
    begin
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // Limit well above the whole sequence
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            close_out;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    end
    endtask

    // Read data only stand in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [7:0] exp);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    end
    endtask

    task watch(input integer n);
        logic last;
        logic last_c;
    begin
        t_dev = 0;
        t_ref = 0;
        t_q = 0;
        t_q4 = 0;
        t_instr_rate_clock_out = 0;
        last = refclk_out_pin;
        last_c = instr_rate_clock_out;
        repeat (n)
        begin
            @(negedge clk_sys);
            t_dev = t_dev + device_clk_tick;
            t_q = t_q + quadrature_phase_first;
            t_q4 = t_q4 + quadrature_phase_fourth;
            t_ref = t_ref + (refclk_out_pin && !last);
            t_instr_rate_clock_out = t_instr_rate_clock_out + (instr_rate_clock_out && !last_c);
            last = refclk_out_pin;
            last_c = instr_rate_clock_out;
        end
    end
    endtask

    task strobe(input logic go_sleep);
    begin
        @(posedge clk_sys);
        if (go_sleep)
            sleep_instr <= 1'b1;
        else
            wake_event <= 1'b1;
        @(posedge clk_sys);
        sleep_instr <= 1'b0;
        wake_event <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    end
    endtask

    task t_reset;
    begin
        for (int i = 0; i < 4; i++)
            rd(i[3:0], 8'h00);
        rd(4'hF, 8'h00);
    end
    endtask

    task t_refclk;
    begin
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'hBF);
        wr(4'h2, 8'h83);
        watch(64);
        chk(t_ref * 8 <= t_dev + 8 && t_ref * 8 + 8 >= t_dev, 1);
        wr(4'h2, 8'h03);
        watch(32);
        chk(t_ref, 0);
    end
    endtask

    task t_secondary;
    begin
        wr(4'h1, 8'h08);
        repeat (2) @(negedge clk_sys);
        chk(secondary_osc_enable, 1);
        wr(4'h1, 8'h00);
        wr(4'h3, 8'h08);
        repeat (2) @(negedge clk_sys);
        chk(secondary_osc_enable, 1);
        rd(4'h3, 8'h08);
        wr(4'h3, 8'h00);
        repeat (2) @(negedge clk_sys);
        chk(secondary_osc_enable, 0);
        wr(4'h0, 8'h01);
        repeat (24) @(posedge clk_sys);
        rd(4'h1, 8'h40);
        rd(4'h0, 8'h01);
    end
    endtask

    task t_primary;
    begin
        wr(4'h0, 8'h00);
        repeat (40) @(posedge clk_sys);
        rd(4'h0, 8'h08);
        rd(4'h1, 8'h00);
        watch(32);
        chk(t_dev, 16);
        chk(t_q, 4);
        chk(t_q4, 4);
    end
    endtask

    task t_idle;
    begin
        wr(4'h0, 8'h80);
        strobe(1'b1);
        chk({idle_active, sleep_active}, 2'b10);
        watch(32);
        chk(t_q, 0);
        strobe(1'b0);
        chk(idle_active, 0);
    end
    endtask

    task t_sleep;
    begin
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h81);
        strobe(1'b1);
        chk({idle_active, sleep_active}, 2'b01);
        watch(32);
        chk(t_dev, 0);
        chk(t_ref, 0);
        wr(4'h2, 8'hB1);
        watch(32);
        chk(t_ref > 6, 1);
        strobe(1'b0);
        chk(sleep_active, 0);
        wr(4'h2, 8'h00);
    end
    endtask

    task t_config;
    begin
        @(posedge clk_sys);
        primary_osc_config <= 4'h4;
        wr(4'h2, 8'h80);
        watch(32);
        chk(t_dev, 16);
        chk(t_instr_rate_clock_out, 4);
        chk(t_ref, 16);
        wr(4'h2, 8'h00);
        primary_osc_config <= 4'h8;
        repeat (4) @(posedge clk_sys);
        rd(4'h0, 8'h00);
        watch(32);
        chk(t_dev, 32);
        chk(t_q4, 8);
        chk(t_instr_rate_clock_out, 8);
    end
    endtask

    task t_mode;
    begin
        @(posedge clk_sys);
        secondary_osc_run_mode <= 2'h2;
        repeat (3) @(negedge clk_sys);
        chk(secondary_digital_in, 1);
    end
    endtask

    initial
    begin
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        sleep_instr = 1'b0;
        wake_event = 1'b0;
        primary_osc_config = 4'h1;
        secondary_osc_run_mode = 2'h1;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_refclk;
        t_secondary;
        t_primary;
        t_idle;
        t_sleep;
        t_config;
        t_mode;
        close_out;
    end
endmodule // test_clock_source_select_and_refclk
